/* core/oag_cfg.svh */
// Constants for the operand address generator: windows, encodings, bank count
`ifndef OAG_CFG_SVH
`define OAG_CFG_SVH

// Short direct window bounds and split point of the 8-bit field
`define OAG_SADDR_LO        16'hFE20
`define OAG_SADDR_HI        16'hFF1F
`define OAG_SADDR_SPLIT     8'h20
`define OAG_SADDR_UPPER7    7'h7F
// Special register page upper byte
`define OAG_SFR_PAGE        8'hFF
// Internal high-speed RAM window usable by the stack
`define OAG_HRAM_LO         16'hFE20
`define OAG_HRAM_HI         16'hFEFF
// Based-mode accumulator load opcode
`define OAG_OPC_LOAD_BASED  8'hAE
// Register and pair numbers inside the bank, starting with the implied accumulator
`define OAG_REG_ACC_BYTE    3'h1
`define OAG_PAIR_ACC        2'h0
`define OAG_PAIR_CNT        2'h1
`define OAG_PAIR_PTR_D      2'h2
`define OAG_PAIR_BASE       2'h3
// Byte registers used as index
`define OAG_REG_IDX_LO      3'h2
`define OAG_REG_IDX_HI      3'h3
// Bank count
`define OAG_NUM_BANKS       4

`endif

/* core/oag_pkg.sv */
// Types shared by the operand address generator
package oag_pkg;

  // Addressing mode requested by the decoder, one-hot
  typedef enum logic [10:0] {
    OAG_MODE_IMPLIED  = 11'h001,
    OAG_MODE_REG8     = 11'h002,
    OAG_MODE_REG16    = 11'h004,
    OAG_MODE_DIRECT   = 11'h008,
    OAG_MODE_SHORT    = 11'h010,
    OAG_MODE_SFR      = 11'h020,
    OAG_MODE_INDIRECT = 11'h040,
    OAG_MODE_BASED    = 11'h080,
    OAG_MODE_BIDX     = 11'h100,
    OAG_MODE_STACK    = 11'h200,
    OAG_MODE_BANKSEL  = 11'h400
  } oag_mode_t;

  // Implied operation class
  typedef enum logic [3:0] {
    OAG_IMP_MUL  = 4'h1,
    OAG_IMP_DIV  = 4'h2,
    OAG_IMP_ADJ  = 4'h4,
    OAG_IMP_ROT  = 4'h8
  } oag_imp_t;

  // Address space targeted by the effective address
  typedef enum logic [2:0] {
    OAG_SPACE_NONE = 3'h1,
    OAG_SPACE_MEM  = 3'h2,
    OAG_SPACE_SFR  = 3'h4
  } oag_space_t;

endpackage

/* core/oag_unit.sv */
// Operand address generator: forms register selects and effective addresses
//
// What this block does
// - Multiply: source accumulator byte, product to accumulator pair
// - Word divide uses accumulator pair both ways
// - Decimal adjust implicitly selects accumulator byte
// - Digit rotate implicitly selects accumulator byte
// - Register select combines bank bits with code
// - Three-bit opcode field picks byte register
// - Direct address is the 16-bit immediate unchanged
// - Short direct reaches FE20H to FF1FH window
// - Bit 8 set for fields 00H..1FH
// - Special register chosen by 8-bit field
// - Indirect address equals selected bank pointer pair
// - Based: base pair plus zero-extended offset
// - Based accumulator load is opcode plus offset
// - Based indexed: base plus index byte, wrap
// - Stack accesses addressed through stack pointer
// - Stack reaches internal high-speed RAM only
// - Four banks, chosen by bank-select instruction
`timescale 1ns/100ps
`include "oag_cfg.svh"

module oag_unit
  import oag_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  // Decoded request from the instruction decoder
  input  wire logic        req_valid,
  input  wire oag_mode_t   req_mode,
  input  wire oag_imp_t    req_imp,
  input  wire logic [7:0]  opcode,
  input  wire logic [7:0]  imm_lo,
  input  wire logic [7:0]  imm_hi,
  input  wire logic [2:0]  reg_code,
  input  wire logic [1:0]  pair_code,
  input  wire logic        index_hi_sel,
  input  wire logic [1:0]  new_bank,
  // Register file contents of the current bank and stack pointer
  input  wire logic [15:0] ptr_d_value,
  input  wire logic [15:0] base_value,
  input  wire logic [7:0]  index_lo_value,
  input  wire logic [7:0]  index_hi_value,
  input  wire logic [15:0] stack_ptr,
  // Bank state
  output logic             bank_select_bit0,
  output logic             bank_select_bit1,
  // Register file selects
  output logic             rf_valid,
  output logic [4:0]       rf_byte_sel,
  output logic [3:0]       rf_pair_sel,
  output logic             rf_pair_mode,
  output logic [3:0]       rf_dst_pair_sel,
  output logic             rf_dst_valid,
  // Memory and special register effective address
  output logic             ea_valid,
  output logic [15:0]      ea_addr,
  output oag_space_t       ea_space,
  output logic             ea_stack,
  output logic             stack_fault,
  output logic             based_load_hit
);

  ////////////////////////////////////////////////////////////////////////////
  // Bank state

  logic [1:0] bank;                // Active bank
  logic [1:0] bank_idx;            // Index prepared for register file
  logic [15:0] next_ea;            // Combinational effective address
  oag_space_t  next_space;         // Combinational target space
  logic        next_ea_valid;      // Combinational address valid
  logic        next_rf_valid;      // Combinational register access
  logic [2:0]  next_reg;           // Byte register inside bank
  logic [1:0]  next_pair;          // Pair inside bank
  logic        next_pair_mode;     // Access is 16-bit
  logic        next_dst;           // Separate destination pair used
  logic [1:0]  next_dst_pair;      // Destination pair inside bank
  logic [16:0] based_sum;          // Base plus offset, top bit dropped
  logic [16:0] bidx_sum;           // Base plus index, top bit dropped
  logic [7:0]  index_byte;         // Chosen index register

  // Bank changes only on the bank-select instruction
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bank <= 2'h0;
    end
    else if (req_valid && req_mode == OAG_MODE_BANKSEL)
    begin
      bank <= new_bank;
    end
  end

  assign bank_select_bit0 = bank[0];
  assign bank_select_bit1 = bank[1];
  assign bank_idx         = bank;

  ////////////////////////////////////////////////////////////////////////////
  // Address arithmetic

  // Offsets are zero-extended; carry past bit 15 is thrown away
  assign based_sum  = {1'b0, base_value} + {9'h000, imm_lo};
  assign index_byte = index_hi_sel ? index_hi_value : index_lo_value;
  assign bidx_sum   = {1'b0, base_value} + {9'h000, index_byte};

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode

  // One path per addressing mode; default keeps everything idle
  always_comb
  begin
    next_ea        = 16'h0000;
    next_space     = OAG_SPACE_NONE;
    next_ea_valid  = 1'b0;
    next_rf_valid  = 1'b0;
    next_reg       = 3'h0;
    next_pair      = 2'h0;
    next_pair_mode = 1'b0;
    next_dst       = 1'b0;
    next_dst_pair  = 2'h0;
    case (req_mode)
      OAG_MODE_IMPLIED:
      begin
        next_rf_valid = 1'b1;
        case (req_imp)
          OAG_IMP_MUL:
          begin
            // Source byte A, result into the accumulator pair
            next_reg      = `OAG_REG_ACC_BYTE;
            next_dst      = 1'b1;
            next_dst_pair = `OAG_PAIR_ACC;
          end
          OAG_IMP_DIV:
          begin
            next_pair_mode = 1'b1;
            next_pair      = `OAG_PAIR_ACC;
            next_dst       = 1'b1;
            next_dst_pair  = `OAG_PAIR_ACC;
          end
          OAG_IMP_ADJ:
          begin
            next_reg = `OAG_REG_ACC_BYTE;
          end
          OAG_IMP_ROT:
          begin
            next_reg = `OAG_REG_ACC_BYTE;
          end
          default:
          begin
            next_rf_valid = 1'b0;               // Unknown class, no access
          end
        endcase
      end
      OAG_MODE_REG8:
      begin
        next_rf_valid = 1'b1;
        next_reg      = opcode[2:0];
      end
      OAG_MODE_REG16:
      begin
        next_rf_valid  = 1'b1;
        next_pair_mode = 1'b1;
        next_pair      = pair_code;
      end
      OAG_MODE_DIRECT:
      begin
        next_ea_valid = 1'b1;
        next_ea       = {imm_hi, imm_lo};
        next_space    = OAG_SPACE_MEM;
      end
      OAG_MODE_SHORT:
      begin
        // Low fields wrap into the first special registers
        next_ea_valid = 1'b1;
        next_ea       = {`OAG_SADDR_UPPER7, (imm_lo < `OAG_SADDR_SPLIT), imm_lo};
        next_space    = (imm_lo < `OAG_SADDR_SPLIT) ? OAG_SPACE_SFR : OAG_SPACE_MEM;
      end
      OAG_MODE_SFR:
      begin
        next_ea_valid = 1'b1;
        next_ea       = {`OAG_SFR_PAGE, imm_lo};
        next_space    = OAG_SPACE_SFR;
      end
      OAG_MODE_INDIRECT:
      begin
        // Only the two pointer pairs may be used as address
        next_ea_valid = 1'b1;
        next_ea       = pair_code[0] ? base_value : ptr_d_value;
        next_space    = OAG_SPACE_MEM;
      end
      OAG_MODE_BASED:
      begin
        next_ea_valid = 1'b1;
        next_ea       = based_sum[15:0];
        next_space    = OAG_SPACE_MEM;
      end
      OAG_MODE_BIDX:
      begin
        next_ea_valid = 1'b1;
        next_ea       = bidx_sum[15:0];
        next_space    = OAG_SPACE_MEM;
      end
      OAG_MODE_STACK:
      begin
        next_ea_valid = 1'b1;
        next_ea       = stack_ptr;
        next_space    = OAG_SPACE_MEM;
      end
      default:
      begin
        next_ea_valid = 1'b0;                   // Bank select and idle
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs

  // Register file selects carry the bank in their upper bits
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rf_valid        <= 1'b0;
      rf_byte_sel     <= 5'h00;
      rf_pair_sel     <= 4'h0;
      rf_pair_mode    <= 1'b0;
      rf_dst_pair_sel <= 4'h0;
      rf_dst_valid    <= 1'b0;
    end
    else
    begin
      rf_valid        <= req_valid && next_rf_valid;
      rf_byte_sel     <= {bank_idx, next_reg};
      rf_pair_sel     <= {bank_idx, next_pair};
      rf_pair_mode    <= next_pair_mode;
      rf_dst_pair_sel <= {bank_idx, next_dst_pair};
      rf_dst_valid    <= req_valid && next_dst;
    end
  end

  // Effective address; stack use outside high-speed RAM is suppressed
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ea_valid    <= 1'b0;
      ea_addr     <= 16'h0000;
      ea_space    <= OAG_SPACE_NONE;
      ea_stack    <= 1'b0;
      stack_fault <= 1'b0;
    end
    else
    begin
      ea_addr  <= next_ea;
      ea_space <= next_space;
      ea_stack <= req_valid && (req_mode == OAG_MODE_STACK);
      if (req_valid && req_mode == OAG_MODE_STACK &&
          (stack_ptr < `OAG_HRAM_LO || stack_ptr > `OAG_HRAM_HI))
      begin
        ea_valid    <= 1'b0;
        stack_fault <= 1'b1;
      end
      else
      begin
        ea_valid    <= req_valid && next_ea_valid;
        stack_fault <= 1'b0;
      end
    end
  end

  // Flags the based-mode accumulator load: opcode then offset byte
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      based_load_hit <= 1'b0;
    end
    else
    begin
      based_load_hit <= req_valid && req_mode == OAG_MODE_BASED &&
                        opcode == `OAG_OPC_LOAD_BASED;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  chk_bank_update: assert property (@(posedge sys_clk) disable iff (!arst_n)
    req_valid && req_mode == OAG_MODE_BANKSEL |=> bank == $past(new_bank))
    else $error("bank not taken from bank select");

  chk_direct_addr: assert property (@(posedge sys_clk) disable iff (!arst_n)
    req_valid && req_mode == OAG_MODE_DIRECT |=> ea_valid && ea_addr == {$past(imm_hi), $past(imm_lo)})
    else $error("direct address altered");

  chk_short_window: assert property (@(posedge sys_clk) disable iff (!arst_n)
    req_valid && req_mode == OAG_MODE_SHORT |=> ea_addr >= `OAG_SADDR_LO && ea_addr <= `OAG_SADDR_HI)
    else $error("short direct outside window");

  chk_short_bit8: assert property (@(posedge sys_clk) disable iff (!arst_n)
    req_valid && req_mode == OAG_MODE_SHORT |=> ea_addr[8] == ($past(imm_lo) < 8'h20))
    else $error("short direct bit 8 wrong");

  chk_sfr_page: assert property (@(posedge sys_clk) disable iff (!arst_n)
    req_valid && req_mode == OAG_MODE_SFR |=> ea_addr == {8'hFF, $past(imm_lo)} && ea_space == OAG_SPACE_SFR)
    else $error("special register address wrong");

  chk_based_wrap: assert property (@(posedge sys_clk) disable iff (!arst_n)
    req_valid && req_mode == OAG_MODE_BASED |=> ea_addr == 16'($past(base_value) + 16'($past(imm_lo))))
    else $error("based address wrong");

  chk_bidx_sum: assert property (@(posedge sys_clk) disable iff (!arst_n)
    req_valid && req_mode == OAG_MODE_BIDX && index_hi_sel
    |=> ea_addr == 16'($past(base_value) + 16'($past(index_hi_value))))
    else $error("based indexed address wrong");

  chk_stack_hram: assert property (@(posedge sys_clk) disable iff (!arst_n)
    ea_valid && ea_stack |-> ea_addr >= `OAG_HRAM_LO && ea_addr <= `OAG_HRAM_HI)
    else $error("stack outside high-speed RAM");

  chk_reg_bank: assert property (@(posedge sys_clk) disable iff (!arst_n)
    req_valid && req_mode == OAG_MODE_REG8 |=> rf_valid && rf_byte_sel == {$past(bank), $past(opcode[2:0])})
    else $error("byte register select wrong");

  chk_mul_implied: assert property (@(posedge sys_clk) disable iff (!arst_n)
    req_valid && req_mode == OAG_MODE_IMPLIED && req_imp == OAG_IMP_MUL
    |=> rf_dst_valid && rf_byte_sel[2:0] == 3'h1 && rf_dst_pair_sel[1:0] == 2'h0)
    else $error("multiply implied operands wrong");

  chk_div_implied: assert property (@(posedge sys_clk) disable iff (!arst_n)
    req_valid && req_mode == OAG_MODE_IMPLIED && req_imp == OAG_IMP_DIV
    |=> rf_pair_mode && rf_pair_sel[1:0] == 2'h0 && rf_dst_pair_sel[1:0] == 2'h0)
    else $error("divide implied operands wrong");

  chk_indirect_ptr: assert property (@(posedge sys_clk) disable iff (!arst_n)
    req_valid && req_mode == OAG_MODE_INDIRECT && !pair_code[0] |=> ea_addr == $past(ptr_d_value))
    else $error("indirect address wrong");

endmodule

/* verification/oag_rf_model.sv */
// Behavioural register file: per-bank pair and index contents
`timescale 1ns/100ps

module oag_rf_model
(
  // Active bank from the unit
  input  wire logic        bank_select_bit0,
  input  wire logic        bank_select_bit1,
  // Current-bank contents toward the unit
  output logic [15:0]      ptr_d_value,
  output logic [15:0]      base_value,
  output logic [7:0]       index_lo_value,
  output logic [7:0]       index_hi_value
);
  logic [1:0] bank;  // Selected bank of four

  ////////////////////////////////////////////////////////////////
  // Bank bits pick one of four banks
  assign bank = {bank_select_bit1, bank_select_bit0};
  // Each bank holds its own contents, so a wrong bank shows
  // Base sits near the top so that offsets wrap past bit 15
  assign ptr_d_value    = {8'hD0, 6'h00, bank};
  assign base_value     = {14'h3FFC, bank};
  assign index_lo_value = {6'h10, bank};
  assign index_hi_value = {6'h3F, bank};
endmodule

/* verification/oag_tb.sv */
// Self-checking bench of the operand address generator
`timescale 1ns/100ps

// Compares a seen value with an expected one and counts it
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end

module testbench;
  import oag_pkg::*;
  logic        sys_clk, arst_n, req_valid, index_hi_sel;  // Stimulus
  oag_mode_t   req_mode;  // Mode request
  oag_imp_t    req_imp;  // Implied class
  logic [7:0]  opcode, imm_lo, imm_hi, idx_lo, idx_hi;  // Fields
  logic [2:0]  reg_code;  // Unused by the unit
  logic [1:0]  pair_code, new_bank, bk;  // bk tracks the bank
  logic [15:0] ptr_d, base, stack_ptr, ea_addr;  // Addresses
  logic        b0, b1, rf_valid, rf_pair_mode, rf_dst_valid;  // Outputs
  logic [4:0]  rf_byte_sel;  // Byte select
  logic [3:0]  rf_pair_sel, rf_dst_pair_sel;  // Pair selects
  logic        ea_valid, ea_stack, stack_fault, based_load_hit;  // EA flags
  oag_space_t  ea_space;  // Target space
  int          n_fail, num_checks, cyc;  // Counters

  ////////////////////////////////////////////////////////////////
  oag_unit dut (.sys_clk(sys_clk), .arst_n(arst_n), .req_valid(req_valid), .req_mode(req_mode),
    .req_imp(req_imp), .opcode(opcode), .imm_lo(imm_lo), .imm_hi(imm_hi), .reg_code(reg_code),
    .pair_code(pair_code), .index_hi_sel(index_hi_sel), .new_bank(new_bank), .ptr_d_value(ptr_d),
    .base_value(base), .index_lo_value(idx_lo), .index_hi_value(idx_hi), .stack_ptr(stack_ptr),
    .bank_select_bit0(b0), .bank_select_bit1(b1), .rf_valid(rf_valid), .rf_byte_sel(rf_byte_sel),
    .rf_pair_sel(rf_pair_sel), .rf_pair_mode(rf_pair_mode), .rf_dst_pair_sel(rf_dst_pair_sel),
    .rf_dst_valid(rf_dst_valid), .ea_valid(ea_valid), .ea_addr(ea_addr), .ea_space(ea_space),
    .ea_stack(ea_stack), .stack_fault(stack_fault), .based_load_hit(based_load_hit));
  oag_rf_model rfm (.bank_select_bit0(b0), .bank_select_bit1(b1), .ptr_d_value(ptr_d),
    .base_value(base), .index_lo_value(idx_lo), .index_hi_value(idx_hi));

  ////////////////////////////////////////////////////////////////
  // Clock and hang guard; the run needs well under 1000 cycles
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_fail++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // One request, outputs sampled mid-cycle after the taking edge
  task automatic go(oag_mode_t m, oag_imp_t i, logic [7:0] op, lo, hi, logic [1:0] pc, logic ih);
    @(posedge sys_clk);
    req_valid <= 1'b1; req_mode <= m; req_imp <= i; opcode <= op;
    imm_lo <= lo; imm_hi <= hi; pair_code <= pc; index_hi_sel <= ih; new_bank <= pc;
    @(posedge sys_clk);
    req_valid <= 1'b0;  // Taken at this edge; dropped so it is taken once
    @(negedge sys_clk);
  endtask

  ////////////////////////////////////////////////////////////////
  task automatic t_reset();
    `CHK("bank", 2'h0, {b1, b0})
    `CHK("space", OAG_SPACE_NONE, ea_space)
    `CHK("valids", 2'h0, {rf_valid, ea_valid})
  endtask

  task automatic t_implied();
    go(OAG_MODE_IMPLIED, OAG_IMP_MUL, 8'h00, 8'h00, 8'h00, 2'h0, 1'b0);
    `CHK("mul src", {bk, 3'h1}, rf_byte_sel)
    `CHK("mul dst", {1'b1, bk, 2'h0}, {rf_dst_valid, rf_dst_pair_sel})
    go(OAG_MODE_IMPLIED, OAG_IMP_DIV, 8'h00, 8'h00, 8'h00, 2'h0, 1'b0);
    `CHK("div", {1'b1, bk, 2'h0, bk, 2'h0}, {rf_pair_mode, rf_pair_sel, rf_dst_pair_sel})
    go(OAG_MODE_IMPLIED, OAG_IMP_ADJ, 8'h00, 8'h00, 8'h00, 2'h0, 1'b0);
    `CHK("adj", {1'b1, bk, 3'h1}, {rf_valid, rf_byte_sel})
    go(OAG_MODE_IMPLIED, OAG_IMP_ROT, 8'h00, 8'h00, 8'h00, 2'h0, 1'b0);
    `CHK("rot", {1'b1, bk, 3'h1}, {rf_valid, rf_byte_sel})
    go(OAG_MODE_IMPLIED, oag_imp_t'(4'h3), 8'h00, 8'h00, 8'h00, 2'h0, 1'b0);
    `CHK("bad imp", 1'b0, rf_valid)
  endtask

  // Every bank, every byte code and every pair code
  task automatic t_regs();
    for (int b = 0; b < 4; b++)
    begin
      go(OAG_MODE_BANKSEL, OAG_IMP_MUL, 8'h00, 8'h00, 8'h00, 2'(b), 1'b0);
      bk = 2'(b);
      `CHK("bank", bk, {b1, b0})
      for (int r = 0; r < 8; r++)
      begin
        go(OAG_MODE_REG8, OAG_IMP_MUL, {5'h00, 3'(r)}, 8'h00, 8'h00, 2'h0, 1'b0);
        `CHK("byte sel", {1'b1, 1'b0, bk, 3'(r)}, {rf_valid, rf_pair_mode, rf_byte_sel})
      end
      for (int p = 0; p < 4; p++)
      begin
        go(OAG_MODE_REG16, OAG_IMP_MUL, 8'h00, 8'h00, 8'h00, 2'(p), 1'b0);
        `CHK("pair sel", {1'b1, bk, 2'(p)}, {rf_pair_mode, rf_pair_sel})
      end
    end
  endtask

  task automatic t_mem();
    logic [7:0] f[4] = '{8'h1F, 8'h20, 8'hFF, 8'h00};
    go(OAG_MODE_DIRECT, OAG_IMP_MUL, 8'h00, 8'h34, 8'hFE, 2'h0, 1'b0);
    `CHK("direct", {1'b1, OAG_SPACE_MEM, 16'hFE34}, {ea_valid, ea_space, ea_addr})
    // Both sides of the split; 20H and 00H double as even word fields
    for (int k = 0; k < 4; k++)
    begin
      go(OAG_MODE_SHORT, OAG_IMP_MUL, 8'h00, f[k], 8'h00, 2'h0, 1'b0);
      `CHK("short", {7'h7F, f[k] < 8'h20, f[k]}, ea_addr)
    end
    go(OAG_MODE_SFR, OAG_IMP_MUL, 8'h00, 8'hE0, 8'h00, 2'h0, 1'b0);
    `CHK("sfr", {OAG_SPACE_SFR, 16'hFFE0}, {ea_space, ea_addr})
    go(OAG_MODE_INDIRECT, OAG_IMP_MUL, 8'h00, 8'h00, 8'h00, 2'h0, 1'b0);
    `CHK("ind d", {8'hD0, 6'h00, bk}, ea_addr)
    go(OAG_MODE_INDIRECT, OAG_IMP_MUL, 8'h00, 8'h00, 8'h00, 2'h1, 1'b0);
    `CHK("ind b", {14'h3FFC, bk}, ea_addr)
    go(OAG_MODE_BASED, OAG_IMP_MUL, 8'hAE, 8'h20, 8'h00, 2'h0, 1'b0);
    `CHK("based", {1'b1, 16'h0010 + bk}, {based_load_hit, ea_addr})
    go(OAG_MODE_BASED, OAG_IMP_MUL, 8'h00, 8'h05, 8'h00, 2'h0, 1'b0);
    `CHK("based2", {1'b0, 16'hFFF5 + bk}, {based_load_hit, ea_addr})
    go(OAG_MODE_BIDX, OAG_IMP_MUL, 8'h00, 8'h00, 8'h00, 2'h0, 1'b0);
    `CHK("bidx lo", 16'h0030 + 2 * bk, ea_addr)
    go(OAG_MODE_BIDX, OAG_IMP_MUL, 8'h00, 8'h00, 8'h00, 2'h0, 1'b1);
    `CHK("bidx hi", 16'h00EC + 2 * bk, ea_addr)
  endtask

  // Window edges pass; one step outside each edge is refused
  task automatic t_stack();
    logic [15:0] sp[4] = '{16'hFE20, 16'hFEFF, 16'hFE1F, 16'hFF00};
    for (int k = 0; k < 4; k++)
    begin
      @(posedge sys_clk);
      stack_ptr <= sp[k];
      go(OAG_MODE_STACK, OAG_IMP_MUL, 8'h00, 8'h00, 8'h00, 2'h0, 1'b0);
      if (k < 2)
        `CHK("stack", {3'b101, sp[k]}, {ea_valid, stack_fault, ea_stack, ea_addr})
      else
        `CHK("stack out", 2'b01, {ea_valid, stack_fault})
    end
  endtask

  ////////////////////////////////////////////////////////////////
  initial
  begin
    {arst_n, req_valid, index_hi_sel, opcode, imm_lo, imm_hi} = '0;
    {reg_code, pair_code, new_bank, bk, n_fail, num_checks, cyc} = '0;
    req_mode = OAG_MODE_IMPLIED;
    req_imp = OAG_IMP_MUL;
    stack_ptr = 16'hFE80;
    repeat (12) @(posedge sys_clk);
    t_reset();
    arst_n <= 1'b1;
    t_implied();
    t_regs();
    t_implied();
    t_mem();
    t_stack();
    test_done();
  end
endmodule
